// ### pbh_bitfield_unit.sv
// Purpose: Bit-field helper datapath of a parallel DSP core
// Assumes: Operands arrive from decode and register file in one cycle
// Notes:   One registered result per operation that writes, latency one clock
//
// Summary of operation
// - Extract moves a chosen byte or halfword down, zero or sign filling above.
// - Replicate repeats the lowest byte or halfword across all 32 result bits.
// - Extract and replicate take only a data-class source; any destination.
// - Mask generator makes n low ones from a 5-bit unsigned count.
// - Leftmost-bit-change gives the highest index differing from the sign bit.
// - Leftmost-one gives the highest index holding a one.
// - Bit indices run 0 at the least significant end to 31 at the top.
// - Expander widens 1, 2 or 4 flag bits by repeating 32, 16 or 8 times.
`timescale 1ns/100ps
module pbh_bitfield_unit
  import pbh_pkg::*;
#(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_rst,
  input  wire logic                         i_valid,
  input  wire pbh_pkg::pbh_op_type          i_op,
  input  wire pbh_pkg::pbh_size_type        i_size,
  input  wire logic [1:0]                   i_field_sel,
  input  wire logic                         i_sign_ext,
  input  wire logic [pbh_pkg::REG_SEL_W-1:0] i_src_sel,
  input  wire logic [pbh_pkg::REG_SEL_W-1:0] i_dst_sel,
  input  wire logic [31:0]                  i_src_data,
  input  wire logic [4:0]                   i_mask_count,
  input  wire pbh_pkg::pbh_exp_type         i_exp_width,
  input  wire logic [pbh_pkg::MF_W-1:0]     i_multiple_flags_reg,
  output logic                              o_wr_en,
  output logic [pbh_pkg::REG_SEL_W-1:0]     o_wr_dst,
  output logic [31:0]                       o_result,
  output logic                              o_overflow,
  output logic                              o_illegal_src
);
  import pbh_pkg::*;

  if (WIDTH != WORD_W) begin : g_width_check
    $error("pbh_bitfield_unit: only 32-bit words are served");
  end

  // Source class check
  wire logic src_is_data = (i_src_sel >= DATA_REG_FIRST) && (i_src_sel <= DATA_REG_LAST);
  wire logic is_move     = (i_op == PBH_OP_EXTRACT) || (i_op == PBH_OP_REPLICATE);
  wire logic bad_src     = i_valid && is_move && !src_is_data;
  wire logic do_write    = i_valid && (i_op != PBH_OP_NONE) && !bad_src;

  // Field extract
  wire logic [7:0]  ext_byte = i_src_data[{i_field_sel, 3'h0} +: 8];
  wire logic [15:0] ext_half = i_src_data[{i_field_sel[0], 4'h0} +: 16];
  wire logic [31:0] ext_b32  = {{24{i_sign_ext & ext_byte[7]}}, ext_byte};
  wire logic [31:0] ext_h32  = {{16{i_sign_ext & ext_half[15]}}, ext_half};
  wire logic [31:0] ext_res  = (i_size == PBH_SIZE_HALF) ? ext_h32 : ext_b32;

  // Field replicate
  wire logic [31:0] rep_res  = (i_size == PBH_SIZE_HALF) ?
                               {2{i_src_data[15:0]}} : {4{i_src_data[7:0]}};

  // Right-justified mask; count 0 gives all zeros
  wire logic [31:0] mask_res = ~(32'hffff_ffff << i_mask_count);

  // Bit detection
  wire logic [31:0] chg_word = i_src_data ^ {32{i_src_data[31]}};
  logic [4:0] lmo_idx;
  logic       lmo_none;
  logic [4:0] lmbc_idx;
  logic       lmbc_none;

  pbh_lead_one #(.WIDTH(WORD_W)) u_lmo (
    .i_word  (i_src_data),
    .o_index (lmo_idx),
    .o_none  (lmo_none)
  );

  pbh_lead_one #(.WIDTH(WORD_W)) u_lmbc (
    .i_word  ({1'b0, chg_word[30:0]}),
    .o_index (lmbc_idx),
    .o_none  (lmbc_none)
  );

  // Expander from the multiple flags register
  wire logic [31:0] exp_1 = {32{i_multiple_flags_reg[0]}};
  wire logic [31:0] exp_2 = {{16{i_multiple_flags_reg[1]}}, {16{i_multiple_flags_reg[0]}}};
  wire logic [31:0] exp_4 = {{8{i_multiple_flags_reg[3]}}, {8{i_multiple_flags_reg[2]}},
                             {8{i_multiple_flags_reg[1]}}, {8{i_multiple_flags_reg[0]}}};
  wire logic [31:0] exp_res = (i_exp_width == PBH_EXP_4BIT) ? exp_4 :
                              (i_exp_width == PBH_EXP_2BIT) ? exp_2 : exp_1;

  // Result selection; failed detection returns index zero
  wire logic ovf_next = (i_op == PBH_OP_LMO)  ? lmo_none :
                        (i_op == PBH_OP_LMBC) ? lmbc_none : 1'b0;
  logic [31:0] result_next;
  always_comb begin
    case (i_op)
      PBH_OP_EXTRACT:   result_next = ext_res;
      PBH_OP_REPLICATE: result_next = rep_res;
      PBH_OP_MASK:      result_next = mask_res;
      PBH_OP_LMO:       result_next = {27'h0, lmo_none ? LSB_INDEX : lmo_idx};
      PBH_OP_LMBC:      result_next = {27'h0, lmbc_none ? LSB_INDEX : lmbc_idx};
      PBH_OP_EXPAND:    result_next = exp_res;
      default:          result_next = RESULT_RST;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_en       <= 1'b0;
      o_wr_dst      <= '0;
      o_result      <= RESULT_RST;
      o_overflow    <= 1'b0;
      o_illegal_src <= 1'b0;
    end else begin
      o_wr_en       <= do_write;
      o_wr_dst      <= i_dst_sel;
      o_result      <= do_write ? result_next : o_result;
      o_overflow    <= do_write & ovf_next;
      o_illegal_src <= bad_src;
    end
  end

  // Assertions
  extract_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_EXTRACT && i_size == PBH_SIZE_BYTE && !i_sign_ext)
      |=> (o_result[31:8] == 24'h0 && o_result[7:0] == $past(ext_byte)))
    else $error("extract byte not zero filled");

  extract_sign_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_EXTRACT && i_size == PBH_SIZE_HALF && i_sign_ext)
      |=> (o_result[31:16] == {16{o_result[15]}}))
    else $error("extract half not sign filled");

  replicate_word_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_REPLICATE && i_size == PBH_SIZE_BYTE)
      |=> (o_result == {4{$past(i_src_data[7:0])}}))
    else $error("replicate byte wrong");

  src_class_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && is_move && (i_src_sel > DATA_REG_LAST)) |=> (!o_wr_en && o_illegal_src))
    else $error("non data source accepted");

  mask_count_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_MASK)
      |=> ($countones(o_result) == $past(i_mask_count) && !o_result[31]
           && (o_result & (o_result + 32'h1)) == 32'h0))
    else $error("mask not right justified");

  bit_change_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_LMBC && i_src_data != 32'h0 && i_src_data != 32'hffff_ffff)
      |=> (($past({1'b0, (i_src_data[30:0] ^ {31{i_src_data[31]}})}) >> o_result[4:0]) == 32'h1
           && !o_overflow))
    else $error("bit change index wrong");

  leading_one_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_LMO && i_src_data != 32'h0)
      |=> ($past(i_src_data) >> o_result[4:0]) == 32'h1)
    else $error("leftmost one index wrong");

  expand_four_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_EXPAND && i_exp_width == PBH_EXP_4BIT)
      |=> (o_result[31:24] == {8{$past(i_multiple_flags_reg[3])}}
           && o_result[7:0] == {8{$past(i_multiple_flags_reg[0])}}))
    else $error("expander lanes wrong");

  detect_overflow_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_LMO && i_src_data == 32'h0)
      |=> (o_overflow && o_result[4:0] == LSB_INDEX))
    else $error("overflow missing on zero operand");

  // Issue patterns built from the operands, not from the unit's own decode,
  // so that a broken decode still trips the checks below that use them
  sequence legal_move_s;
    i_valid && (i_op == PBH_OP_EXTRACT || i_op == PBH_OP_REPLICATE)
      && (i_src_sel <= DATA_REG_LAST);
  endsequence

  sequence refused_move_s;
    i_valid && (i_op == PBH_OP_EXTRACT || i_op == PBH_OP_REPLICATE)
      && (i_src_sel > DATA_REG_LAST);
  endsequence

  sequence uniform_change_s;
    i_valid && i_op == PBH_OP_LMBC && (i_src_data == 32'h0 || i_src_data == 32'hffff_ffff);
  endsequence

  extract_hzero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_EXTRACT && i_size == PBH_SIZE_HALF && !i_sign_ext)
      |=> (o_result == {16'h0, $past(ext_half)}))
    else $error("extract half not zero filled");

  extract_bsign_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_EXTRACT && i_size == PBH_SIZE_BYTE && i_sign_ext)
      |=> (o_result == {{24{$past(ext_byte[7])}}, $past(ext_byte)}))
    else $error("extract byte not sign filled");

  replicate_half_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_REPLICATE && i_size == PBH_SIZE_HALF)
      |=> (o_result == {2{$past(i_src_data[15:0])}}))
    else $error("replicate half wrong");

  legal_move_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    legal_move_s |=> (o_wr_en && !o_illegal_src))
    else $error("data source move refused");

  refused_hold_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    refused_move_s |=> $stable(o_result))
    else $error("refused move changed result");

  dest_echo_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_valid |=> (o_wr_dst == $past(i_dst_sel)))
    else $error("destination code not carried");

  expand_one_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_EXPAND && i_exp_width == PBH_EXP_1BIT)
      |=> (o_result == {32{$past(i_multiple_flags_reg[0])}}))
    else $error("single flag expansion wrong");

  expand_two_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (do_write && i_op == PBH_OP_EXPAND && i_exp_width == PBH_EXP_2BIT)
      |=> (o_result == {{16{$past(i_multiple_flags_reg[1])}},
                        {16{$past(i_multiple_flags_reg[0])}}}))
    else $error("two flag expansion wrong");

  change_empty_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    uniform_change_s |=> (o_overflow && o_result[4:0] == LSB_INDEX))
    else $error("overflow missing on uniform operand");

  found_clear_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_valid && i_op == PBH_OP_LMO && i_src_data != 32'h0)
      |=> (o_wr_en && !o_overflow))
    else $error("overflow raised with a one present");
endmodule : pbh_bitfield_unit

// ### pbh_lead_one.sv
// Purpose: Leftmost-one finder over a word
// Assumes: Purely combinational, used by the helper datapath
// Notes:   o_none is high when no bit is set
`timescale 1ns/100ps
module pbh_lead_one #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic [WIDTH-1:0]         i_word,
  output logic      [$clog2(WIDTH)-1:0] o_index,
  output logic                          o_none
);
  // Elaboration guard: a one-bit word leaves no index field
  if (WIDTH < 2) begin : g_width_check
    $error("pbh_lead_one: WIDTH must be at least 2");
  end

  // Lowest-first scan so the highest set bit wins
  always_comb begin
    o_index = '0;
    o_none  = 1'b1;
    for (int unsigned k = 0; k < WIDTH; k++) begin
      if (i_word[k]) begin
        o_index = k[$clog2(WIDTH)-1:0];
        o_none  = 1'b0;
      end
    end
  end
endmodule : pbh_lead_one

// ### pbh_pkg.sv
// Purpose: Shared constants for the bit-field helper datapath
// Assumes: 32-bit words, bit 0 least significant
// Notes:   Operation codes select the function computed each cycle
package pbh_pkg;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned IDX_W      = 5;
  localparam int unsigned REG_SEL_W  = 6;
  localparam int unsigned MF_W       = 4;
  localparam logic [31:0] RESULT_RST = 32'h0000_0000;
  localparam logic [4:0]  INDEX_RST  = 5'h00;
  localparam logic [4:0]  MSB_INDEX  = 5'h1f;
  localparam logic [4:0]  LSB_INDEX  = 5'h00;
  // Data-class registers occupy the low codes of the register select space
  localparam logic [5:0]  DATA_REG_FIRST = 6'h00;
  localparam logic [5:0]  DATA_REG_LAST  = 6'h07;

  typedef enum logic [3:0] {
    PBH_OP_NONE,
    PBH_OP_EXTRACT,
    PBH_OP_REPLICATE,
    PBH_OP_MASK,
    PBH_OP_LMO,
    PBH_OP_LMBC,
    PBH_OP_EXPAND
  } pbh_op_type;

  typedef enum logic [1:0] {
    PBH_SIZE_BYTE,
    PBH_SIZE_HALF
  } pbh_size_type;

  typedef enum logic [1:0] {
    PBH_EXP_1BIT,
    PBH_EXP_2BIT,
    PBH_EXP_4BIT
  } pbh_exp_type;
endpackage : pbh_pkg

// ### pbh_rf_model.sv
// Purpose: Register file stand-in feeding the helper datapath
// Assumes: Read is combinational, write lands on the rising edge
// Notes:   The bench preloads entries directly before each operation
`timescale 1ns/100ps
module pbh_rf_model (
  input  wire logic        i_ref_clk,
  input  wire logic [5:0]  i_rd_sel,
  input  wire logic        i_wr_en,
  input  wire logic [5:0]  i_wr_sel,
  input  wire logic [31:0] i_wr_data,
  output logic      [31:0] o_rd_data
);
  logic [31:0] mem_reg [64];
  assign o_rd_data = mem_reg[i_rd_sel];
  always @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem_reg[i_wr_sel] <= i_wr_data;
    end
  end
endmodule : pbh_rf_model

// ### tb.sv
// Purpose: Self-checking bench for the bit-field helper datapath
// Assumes: Result, flags and write enable appear one clock after issue
// Notes:   Each issue judges the previous op, so ops run back to back
`timescale 1ns/100ps
module tb;
  import pbh_pkg::*;
  logic         clk, rst, vld, sgn, wr_en, ovf, ill, pend, e_wr, e_ovf, e_ill;
  pbh_op_type   op;
  pbh_size_type sz;
  pbh_exp_type  ew;
  logic [1:0]   fsel;
  logic [5:0]   ssel, dsel, wdst, e_dst;
  logic [31:0]  sdata, res, last_res, e_res, v;
  logic [4:0]   cnt;
  logic [3:0]   flg;
  int           n_errors, total_checks;
  pbh_rf_model rf (.i_ref_clk(clk), .i_rd_sel(ssel), .i_wr_en(wr_en), .i_wr_sel(wdst),
                   .i_wr_data(res), .o_rd_data(sdata));
  pbh_bitfield_unit dut (.i_ref_clk(clk), .i_rst(rst), .i_valid(vld), .i_op(op), .i_size(sz),
    .i_field_sel(fsel), .i_sign_ext(sgn), .i_src_sel(ssel), .i_dst_sel(dsel),
    .i_src_data(sdata), .i_mask_count(cnt), .i_exp_width(ew), .i_multiple_flags_reg(flg),
    .o_wr_en(wr_en), .o_wr_dst(wdst), .o_result(res), .o_overflow(ovf), .o_illegal_src(ill));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task issue(input pbh_op_type o, input int s, k, x, src, input logic [31:0] d,
             input int n, e, fl, input logic [31:0] r, input logic w, f, il);
    @(negedge clk);
    if (pend) begin
      check({31'h0, wr_en}, {31'h0, e_wr});
      check(res, e_res);
      check({31'h0, ovf}, {31'h0, e_ovf});
      check({31'h0, ill}, {31'h0, e_ill});
      check({26'h0, wdst}, {26'h0, e_dst});
    end
    rf.mem_reg[src[5:0]] = d;
    op = o; sz = pbh_size_type'(s); fsel = k[1:0]; sgn = x[0]; ssel = src[5:0];
    cnt = n[4:0]; ew = pbh_exp_type'(e); flg = fl[3:0]; vld = 1; e_dst = dsel + 6'h01;
    dsel = e_dst;
    e_wr = w; e_ovf = f; e_ill = il; pend = 1;
    if (w) last_res = r;
    e_res = last_res;
  endtask : issue
  task det(input pbh_op_type o, input logic [31:0] d, input int r, input logic f);
    issue(o, 0, 0, 0, 0, d, 0, 0, 0, r, 1, f, 0);
  endtask : det
  task drain;
    issue(PBH_OP_NONE, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0);
  endtask : drain
  task finish_test;
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task t_fields;
    for (int k = 0; k < 4; k++) for (int x = 0; x < 2; x++) begin
      v = 32'h8c7f_a512 >> (8 * k);
      issue(PBH_OP_EXTRACT, 0, k, x, k, 32'h8c7f_a512, 0, 0, 0,
            x ? {{24{v[7]}}, v[7:0]} : {24'h0, v[7:0]}, 1, 0, 0);
      v = 32'h8c7f_a512 >> (16 * (k % 2));
      issue(PBH_OP_EXTRACT, 1, k % 2, x, 7, 32'h8c7f_a512, 0, 0, 0,
            x ? {{16{v[15]}}, v[15:0]} : {16'h0, v[15:0]}, 1, 0, 0);
    end
    issue(PBH_OP_REPLICATE, 0, 0, 0, 7, 32'h1234_56c9, 0, 0, 0, {4{8'hc9}}, 1, 0, 0);
    issue(PBH_OP_REPLICATE, 1, 0, 0, 3, 32'h1234_56c9, 0, 0, 0, {2{16'h56c9}}, 1, 0, 0);
    issue(PBH_OP_EXTRACT, 0, 1, 1, 8, 32'h0000_8000, 0, 0, 0, 0, 0, 0, 1);
    issue(PBH_OP_REPLICATE, 1, 0, 0, 63, 32'h0000_ffff, 0, 0, 0, 0, 0, 0, 1);
    drain;
  endtask : t_fields
  task t_mask;
    for (int n = 0; n < 32; n++)
      issue(PBH_OP_MASK, 0, 0, 0, 0, 0, n, 0, 0, (32'h1 << n) - 32'h1, 1, 0, 0);
    drain;
  endtask : t_mask
  task t_detect;
    for (int i = 0; i < 32; i++) begin
      v = 32'h1 << i;
      det(PBH_OP_LMO, v | ((v - 32'h1) & 32'h5555_5555), i, 0);
      if (i < 31) det(PBH_OP_LMBC, v, i, 0);
      if (i < 31) det(PBH_OP_LMBC, ~v, i, 0);
    end
    det(PBH_OP_LMO, 32'h0, 0, 1);
    det(PBH_OP_LMBC, 32'h0, 0, 1);
    det(PBH_OP_LMBC, 32'hffff_ffff, 0, 1);
    drain;
  endtask : t_detect
  task t_expand;
    for (int fl = 0; fl < 16; fl++) for (int e = 0; e < 3; e++) begin
      for (int b = 0; b < 32; b++) v[b] = fl[b / (32 >> e)];
      issue(PBH_OP_EXPAND, 0, 0, 0, 0, 0, 0, e, fl, v, 1, 0, 0);
    end
    drain;
  endtask : t_expand
  initial begin
    rst = 1; vld = 0; op = PBH_OP_NONE; sz = PBH_SIZE_BYTE; ew = PBH_EXP_1BIT; fsel = 0;
    sgn = 0; ssel = 0; dsel = 0; cnt = 0; flg = 0; pend = 0; last_res = 0;
    n_errors = 0; total_checks = 0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    check(res, RESULT_RST);
    check({29'h0, wr_en, ovf, ill}, 32'h0);
    rst = 0;
    t_fields;
    t_mask;
    t_detect;
    t_expand;
    finish_test;
  end
endmodule : tb
